// ---- core/dcrt_rx_time_core.sv ----
// Overview of operation
// [R1] A broadcast_write or configured_address_write to the port-0 receive-time register captures each port's preamble-start local time.
// [R2] Reading the port-0 receive-time register returns the capture from the latest frame that carried that trigger write.
// [R3] New timestamps become readable only after the triggering frame has ended, never inside it.
// [R4] The port-1 receive-time register holds port 1's preamble-start time of the triggering frame.
// [R5] Timestamps are 32 or 64 bits wide according to the distributed-clock width chosen.
// [R6] A fieldbus read of system time returns the copy plus propagation delay latched at start of frame.
// [R7] A host read of the lowest system-time byte snapshots all 64 bits so later bytes stay consistent.
// [R8] A fieldbus write reaching the lowest system-time byte is compared at frame end with the start-of-frame copy.
// [R9] A host write covering the fourth system-time byte is compared at access end with the latch_input_zero rising-edge time.
// [R10] System-time writes come from the fieldbus only, unless host-controlled system time is selected.
// [R11] The processing-unit receive-time register holds a 64-bit preamble-start time of the triggering frame.
// [R12] With port 0 open the processing-unit receive time equals the port-0 stamp as a 64-bit value.
// [R13] The system time copy is the free-running local time plus the 64-bit offset.
// [R14] The local time counter runs from reset and advances on every clock with CE high, feeding all timestamps.
// [R15] Host writes to the receive-time registers have no effect.
module dcrt_rx_time_core #(
	parameter int DC_WIDTH = 64
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire dcrt_pkg::dcrt_acc_s FB_ACC,
	input wire logic FB_CMD_BCAST_WR,
	input wire logic FB_CMD_CFG_WR,
	input wire logic [2:0] PREAMBLE_START,
	input wire logic FB_SOF,
	input wire logic FB_EOF,
	input wire logic PORT0_OPEN,
	input wire dcrt_pkg::dcrt_acc_s HS_ACC,
	input wire logic HS_ACC_END,
	input wire logic HS_SYSTIME_CTRL,
	input wire logic [63:0] SYS_TIME_OFFSET,
	input wire logic [31:0] SYS_TIME_DELAY,
	input wire logic [63:0] LATCH_INPUT_ZERO_POS_TIME,
	output logic [7:0] FB_RDATA,
	output logic FB_RVALID,
	output logic [7:0] HS_RDATA,
	output logic HS_RVALID,
	output logic [31:0] LOOP_DIFF,
	output logic LOOP_VALID,
	output logic LOOP_FROM_HOST
);
	import dcrt_pkg::*;

	// ************************************************************
	// Elaboration check
	// ************************************************************
	if (DC_WIDTH != DC_WIDTH_NARROW && DC_WIDTH != DC_WIDTH_WIDE) begin : g_width_chk
		$error("DC_WIDTH must be 32 or 64");
	end

	// ************************************************************
	// Time base and receive stamps
	// ************************************************************
	logic [63:0] local_time;
	logic [63:0] sys_time;
	logic [63:0] stamp_p0;
	logic [63:0] stamp_p1;
	logic [63:0] stamp_pu;
	logic trig_ff;
	logic trig_now;
	logic commit;
	logic pu_capture;

	dcrt_local_time #(
		.DC_WIDTH(DC_WIDTH)
	) u_time (
		.clk(REF_CLK),
		.rst(RST),
		.ce(CE),
		.offset(SYS_TIME_OFFSET),
		.local_time(local_time),
		.sys_time(sys_time)
	);

	// Only the first register byte with one of the two write commands arms it.
	assign trig_now = FB_ACC.wr && FB_ACC.addr == RX_TIME_PORT_ZERO_ADDR &&
		(FB_CMD_BCAST_WR || FB_CMD_CFG_WR); // see [R1]
	// A trigger in the end-of-frame cycle itself still commits.
	assign commit = FB_EOF && (trig_ff || trig_now); // see [R3]
	// Port 0 open means the processing unit sees the port-0 preamble.
	assign pu_capture = PORT0_OPEN ? PREAMBLE_START[PREAMBLE_PORT_ZERO_BIT] :
		PREAMBLE_START[PREAMBLE_PROC_UNIT_BIT]; // see [R12]

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			trig_ff <= 1'b0;
		end else if (CE) begin
			if (FB_EOF) begin
				trig_ff <= 1'b0;
			end else if (trig_now) begin
				trig_ff <= 1'b1;
			end
		end
	end

	dcrt_stamp u_stamp_p0 (
		.clk(REF_CLK),
		.rst(RST),
		.ce(CE),
		.capture(PREAMBLE_START[PREAMBLE_PORT_ZERO_BIT]),
		.commit(commit),
		.now(local_time),
		.stamp(stamp_p0)
	);

	dcrt_stamp u_stamp_p1 (
		.clk(REF_CLK),
		.rst(RST),
		.ce(CE),
		.capture(PREAMBLE_START[PREAMBLE_PORT_ONE_BIT]),
		.commit(commit),
		.now(local_time),
		.stamp(stamp_p1)
	);

	dcrt_stamp u_stamp_pu (
		.clk(REF_CLK),
		.rst(RST),
		.ce(CE),
		.capture(pu_capture),
		.commit(commit),
		.now(local_time),
		.stamp(stamp_pu)
	);

	// ************************************************************
	// Start-of-frame system time latch and host snapshot
	// ************************************************************
	logic [63:0] sof_ff;
	logic [63:0] snap_ff;
	logic hs_snap_rd;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sof_ff <= TIME_RESET;
		end else if (CE && FB_SOF) begin
			sof_ff <= sys_time + 64'(SYS_TIME_DELAY); // see [R6]
		end
	end

	assign hs_snap_rd = HS_ACC.rd && HS_ACC.addr == SYSTEM_TIME_VALUE_ADDR;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			snap_ff <= TIME_RESET;
		end else if (CE && hs_snap_rd) begin
			snap_ff <= sys_time; // see [R7]
		end
	end

	// ************************************************************
	// Read decode
	// ************************************************************
	// The 32-bit port registers only show the low word of the stamp; in the
	// 32-bit build the upper bytes of the 64-bit registers read as zero, save a delay carry into bit 32 of the fieldbus system time.
	function automatic logic [7:0] rd_byte(input logic [15:0] addr, input logic [63:0] st);
		logic [7:0] res;
		res = RDATA_RESET;
		if (addr >= RX_TIME_PORT_ZERO_ADDR && addr < RX_TIME_PORT_ONE_ADDR) begin
			res = dcrt_byte({32'h0000_0000, stamp_p0[31:0]}, addr[2:0]); // see [R2]
		end else if (addr >= RX_TIME_PORT_ONE_ADDR && addr < RX_TIME_PORT_ONE_ADDR + 16'h0004) begin
			res = dcrt_byte({32'h0000_0000, stamp_p1[31:0]}, 3'(addr[1:0])); // see [R4]
		end else if (addr >= SYSTEM_TIME_VALUE_ADDR && addr < RX_TIME_PROCESSING_UNIT_ADDR) begin
			res = dcrt_byte(st, addr[2:0]);
		end else if (addr >= RX_TIME_PROCESSING_UNIT_ADDR && addr <= DC_WINDOW_END_ADDR) begin
			res = dcrt_byte(stamp_pu, addr[2:0]); // see [R11]
		end
		return res;
	endfunction

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			FB_RDATA <= RDATA_RESET;
			FB_RVALID <= 1'b0;
		end else if (CE) begin
			FB_RVALID <= FB_ACC.rd;
			if (FB_ACC.rd) begin
				FB_RDATA <= rd_byte(FB_ACC.addr, sof_ff); // see [R6]
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			HS_RDATA <= RDATA_RESET;
			HS_RVALID <= 1'b0;
		end else if (CE) begin
			HS_RVALID <= HS_ACC.rd;
			if (HS_ACC.rd) begin
				// The lowest byte comes from the live copy that is snapshotted.
				HS_RDATA <= rd_byte(HS_ACC.addr, hs_snap_rd ? sys_time : snap_ff); // see [R7]
			end
		end
	end

	// ************************************************************
	// System time writes into the time control loop
	// ************************************************************
	logic fb_st_wr;
	logic hs_st_wr;
	logic [31:0] fb_wbuf_ff;
	logic [31:0] hs_wbuf_ff;
	logic [31:0] nxt_fb_wbuf;
	logic [31:0] nxt_hs_wbuf;
	logic fb_low_ff;
	logic hs_high_ff;
	logic fb_cmp;
	logic hs_cmp;
	logic hs_pend_ff;
	logic [31:0] hs_diff_ff;

	// Writes to the receive-time registers from the host side are simply not
	// decoded, so they never disturb a stamp.
	// see [R15]
	assign fb_st_wr = FB_ACC.wr && !HS_SYSTIME_CTRL && FB_ACC.addr >= SYSTEM_TIME_VALUE_ADDR &&
		FB_ACC.addr <= SYSTEM_TIME_LAST_CMP_ADDR; // see [R10]
	assign hs_st_wr = HS_ACC.wr && HS_SYSTIME_CTRL && HS_ACC.addr >= SYSTEM_TIME_VALUE_ADDR &&
		HS_ACC.addr <= SYSTEM_TIME_LAST_CMP_ADDR; // see [R10]

	always_comb begin
		nxt_fb_wbuf = fb_wbuf_ff;
		nxt_hs_wbuf = hs_wbuf_ff;
		if (fb_st_wr) begin
			nxt_fb_wbuf[{FB_ACC.addr[1:0], 3'h0} +: 8] = FB_ACC.wdata;
		end
		if (hs_st_wr) begin
			nxt_hs_wbuf[{HS_ACC.addr[1:0], 3'h0} +: 8] = HS_ACC.wdata;
		end
	end

	assign fb_cmp = FB_EOF && (fb_low_ff ||
		(fb_st_wr && FB_ACC.addr == SYSTEM_TIME_VALUE_ADDR)); // see [R8]
	assign hs_cmp = HS_ACC_END && (hs_high_ff ||
		(hs_st_wr && HS_ACC.addr == SYSTEM_TIME_LAST_CMP_ADDR)); // see [R9]

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			fb_wbuf_ff <= TIME_RESET[31:0];
			hs_wbuf_ff <= TIME_RESET[31:0];
		end else if (CE) begin
			fb_wbuf_ff <= nxt_fb_wbuf;
			hs_wbuf_ff <= nxt_hs_wbuf;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			fb_low_ff <= 1'b0;
			hs_high_ff <= 1'b0;
		end else if (CE) begin
			if (FB_EOF) begin
				fb_low_ff <= 1'b0;
			end else if (fb_st_wr && FB_ACC.addr == SYSTEM_TIME_VALUE_ADDR) begin
				fb_low_ff <= 1'b1;
			end
			if (HS_ACC_END) begin
				hs_high_ff <= 1'b0;
			end else if (hs_st_wr && HS_ACC.addr == SYSTEM_TIME_LAST_CMP_ADDR) begin
				hs_high_ff <= 1'b1;
			end
		end
	end

	// A host result that meets a fieldbus result waits one slot instead of
	// being dropped; the loop sees the fieldbus one first.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			hs_pend_ff <= 1'b0;
			hs_diff_ff <= TIME_RESET[31:0];
		end else if (CE) begin
			if (hs_cmp) begin
				hs_pend_ff <= 1'b1;
				hs_diff_ff <= nxt_hs_wbuf - LATCH_INPUT_ZERO_POS_TIME[CMP_WIDTH-1:0]; // see [R9]
			end else if (!fb_cmp) begin
				hs_pend_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			LOOP_DIFF <= TIME_RESET[31:0];
			LOOP_VALID <= 1'b0;
			LOOP_FROM_HOST <= 1'b0;
		end else if (CE) begin
			LOOP_VALID <= fb_cmp || hs_pend_ff;
			if (fb_cmp) begin
				LOOP_DIFF <= nxt_fb_wbuf - sof_ff[CMP_WIDTH-1:0]; // see [R8]
				LOOP_FROM_HOST <= 1'b0;
			end else if (hs_pend_ff) begin
				LOOP_DIFF <= hs_diff_ff;
				LOOP_FROM_HOST <= 1'b1;
			end
		end
	end

	// Stamp widths follow DC_WIDTH through the local time counter.
	// see [R5]

endmodule

// ---- shared/dcrt_pkg.sv ----
package dcrt_pkg;

	// ************************************************************
	// Register byte addresses
	// ************************************************************
	localparam logic [15:0] RX_TIME_PORT_ZERO_ADDR = 16'h0900;
	localparam logic [15:0] RX_TIME_PORT_ONE_ADDR = 16'h0904;
	localparam logic [15:0] SYSTEM_TIME_VALUE_ADDR = 16'h0910;
	localparam logic [15:0] RX_TIME_PROCESSING_UNIT_ADDR = 16'h0918;
	localparam logic [15:0] SYSTEM_TIME_LAST_CMP_ADDR = 16'h0913;
	localparam logic [15:0] DC_WINDOW_END_ADDR = 16'h091F;

	// ************************************************************
	// Field layout and reset values
	// ************************************************************
	localparam int PREAMBLE_PORT_ZERO_BIT = 0;
	localparam int PREAMBLE_PORT_ONE_BIT = 1;
	localparam int PREAMBLE_PROC_UNIT_BIT = 2;
	localparam int CMP_WIDTH = 32;
	localparam int DC_WIDTH_NARROW = 32;
	localparam int DC_WIDTH_WIDE = 64;
	localparam logic [63:0] TIME_RESET = 64'h0000_0000_0000_0000;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	// One byte-wide register access, used for both the fieldbus and host sides.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} dcrt_acc_s;

	// Pick one byte out of a 64-bit word.
	function automatic logic [7:0] dcrt_byte(input logic [63:0] word, input logic [2:0] idx);
		dcrt_byte = word[{idx, 3'h0} +: 8];
	endfunction

endpackage

// ---- core/dcrt_local_time.sv ----
module dcrt_local_time #(
	parameter int DC_WIDTH = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [63:0] offset,
	output logic [63:0] local_time,
	output logic [63:0] sys_time
);
	import dcrt_pkg::*;

	logic [DC_WIDTH-1:0] local_ff;
	logic [DC_WIDTH-1:0] sys_ff;

	// ************************************************************
	// Free-running local time and system time copy
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			local_ff <= TIME_RESET[DC_WIDTH-1:0];
		end else if (ce) begin
			local_ff <= local_ff + DC_WIDTH'(1); // see [R14]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sys_ff <= TIME_RESET[DC_WIDTH-1:0];
		end else if (ce) begin
			sys_ff <= local_ff + offset[DC_WIDTH-1:0]; // see [R13]
		end
	end

	assign local_time = 64'(local_ff);
	assign sys_time = 64'(sys_ff);

endmodule

// ---- core/dcrt_stamp.sv ----
module dcrt_stamp (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic capture,
	input wire logic commit,
	input wire logic [63:0] now,
	output logic [63:0] stamp
);
	import dcrt_pkg::*;

	logic [63:0] pend_ff;
	logic [63:0] stamp_ff;
	logic [63:0] nxt_pend;

	// ************************************************************
	// Preamble capture, published only at frame end
	// ************************************************************
	// Every preamble is caught, but the value only becomes visible when the
	// frame turns out to carry the trigger write; other frames leave it alone.
	assign nxt_pend = capture ? now : pend_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			pend_ff <= TIME_RESET;
		end else if (ce) begin
			pend_ff <= nxt_pend;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stamp_ff <= TIME_RESET;
		end else if (ce && commit) begin
			stamp_ff <= nxt_pend; // see [R3]
		end
	end

	assign stamp = stamp_ff;

endmodule

// ---- verification/dcrt_chk.sv ----
module dcrt_chk (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire dcrt_pkg::dcrt_acc_s FB_ACC,
	input wire logic FB_EOF,
	input wire dcrt_pkg::dcrt_acc_s HS_ACC,
	input wire logic HS_ACC_END,
	input wire logic HS_SYSTIME_CTRL,
	input wire logic FB_RVALID,
	input wire logic HS_RVALID,
	input wire logic [31:0] LOOP_DIFF,
	input wire logic LOOP_VALID,
	input wire logic LOOP_FROM_HOST
);
	timeunit 1ns;
	timeprecision 100ps;
	import dcrt_pkg::*;
	// ****
	// Frame bookkeeping
	// ****
	logic st_ff;
	logic st_now;
	assign st_now = FB_ACC.wr && FB_ACC.addr == SYSTEM_TIME_VALUE_ADDR;
	// A write in the end-of-frame cycle still counts for that frame.
	always_ff @(posedge REF_CLK) begin
		st_ff <= (RST || FB_EOF) ? 1'b0 : (st_ff || st_now);
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	a_fb_rd_answer: assert property (FB_ACC.rd |=> FB_RVALID)
		else $error("fieldbus read not answered");
	a_hs_rd_answer: assert property (HS_ACC.rd |=> HS_RVALID)
		else $error("host read not answered");
	a_fb_rd_cause: assert property (FB_RVALID |-> $past(FB_ACC.rd))
		else $error("fieldbus answer without read");
	a_fb_loop_eof: assert property (FB_EOF && (st_ff || st_now) && !HS_SYSTIME_CTRL
		|=> LOOP_VALID && !LOOP_FROM_HOST) else $error("fieldbus compare missing");
	a_fb_loop_src: assert property (LOOP_VALID && !LOOP_FROM_HOST
		|-> $past(FB_EOF) && !$past(HS_SYSTIME_CTRL)) else $error("stray fieldbus compare");
	a_hs_loop_lat: assert property (HS_ACC_END && HS_ACC.wr && HS_SYSTIME_CTRL
		&& HS_ACC.addr == SYSTEM_TIME_LAST_CMP_ADDR |-> ##[2:3] LOOP_VALID && LOOP_FROM_HOST)
		else $error("host compare missing");
	a_hs_loop_mode: assert property (LOOP_VALID && LOOP_FROM_HOST
		|-> $past(HS_SYSTIME_CTRL, 2)) else $error("host compare outside host mode");
	a_loop_diff_hold: assert property (!LOOP_VALID |-> $stable(LOOP_DIFF))
		else $error("loop difference moved");
	c_fb_loop: cover property (LOOP_VALID && !LOOP_FROM_HOST);
	c_hs_loop: cover property (LOOP_VALID && LOOP_FROM_HOST);
	c_hs_read: cover property (HS_RVALID);
endmodule
bind dcrt_rx_time_core dcrt_chk i_dcrt_chk (.REF_CLK, .RST, .FB_ACC, .FB_EOF, .HS_ACC,
	.HS_ACC_END, .HS_SYSTIME_CTRL, .FB_RVALID, .HS_RVALID, .LOOP_DIFF, .LOOP_VALID,
	.LOOP_FROM_HOST);

// ---- verification/dcrt_far.sv ----
module dcrt_far (
	input wire logic clk,
	input wire logic [7:0] rdata,
	output dcrt_pkg::dcrt_acc_s acc,
	output logic bcast,
	output logic cfg,
	output logic [2:0] pre,
	output logic sof,
	output logic eof
);
	timeunit 1ns;
	timeprecision 100ps;
	import dcrt_pkg::*;
	initial begin
		acc = '0;
		{cfg, bcast, pre, sof, eof} = '0;
	end
	task automatic pulse(input logic [2:0] p, input logic s, input logic e);
		{pre, sof, eof} = {p, s, e};
		@(posedge clk) #1;
	endtask
	// Stamps are fetched both inside the frame, before the end-of-frame pulse, and after it.
	task automatic op(input logic w, input logic [15:0] a, input logic [7:0] d,
		input logic [1:0] c, output logic [7:0] q);
		acc = '{wr: w, rd: !w, addr: a, wdata: d};
		{cfg, bcast, pre, sof, eof} = {c, 5'h00};
		@(posedge clk) #1;
		q = rdata;
	endtask
	// Released lines show the inverse so a stale value is never mistaken for data.
	task automatic rel();
		acc = '{wr: 1'b0, rd: 1'b0, addr: ~acc.addr, wdata: ~acc.wdata};
		{cfg, bcast, pre, sof, eof} = '0;
		@(posedge clk) #1;
	endtask
endmodule

// ---- verification/dcrt_rx_time_core_test.sv ----
module dcrt_rx_time_core_test;
	timeunit 1ns;
	timeprecision 100ps;
	import dcrt_pkg::*;
	localparam logic [15:0] RT0 = RX_TIME_PORT_ZERO_ADDR;
	localparam logic [15:0] ST = SYSTEM_TIME_VALUE_ADDR;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hs_end = 1'b0;
	logic ctrl = 1'b0;
	logic po = 1'b0;
	logic ce = 1'b1;
	logic fb_rv, hs_rv, lv, lh, bc, cf, sof, eof;
	logic [2:0] pre;
	logic [7:0] fb_q, hs_q;
	logic [31:0] ld;
	logic [63:0] lt;
	dcrt_acc_s fb_acc;
	dcrt_acc_s hs_acc = '0;
	int n_fail = 0;
	int compares = 0;
	always #5 clk = ~clk;
	// The reference time freezes with the clock enable, as the local time counter must.
	always @(posedge clk) lt <= rst ? 64'h0 : lt + 64'(ce);
	dcrt_rx_time_core i_dcrt_rx_time_core (.REF_CLK(clk), .RST(rst), .CE(ce), .FB_ACC(fb_acc),
		.FB_CMD_BCAST_WR(bc), .FB_CMD_CFG_WR(cf), .PREAMBLE_START(pre), .FB_SOF(sof), .FB_EOF(eof),
		.PORT0_OPEN(po), .HS_ACC(hs_acc), .HS_ACC_END(hs_end), .HS_SYSTIME_CTRL(ctrl),
		.SYS_TIME_OFFSET(64'h1_0000_0000), .SYS_TIME_DELAY(32'h1234),
		.LATCH_INPUT_ZERO_POS_TIME(64'h1000), .FB_RDATA(fb_q), .FB_RVALID(fb_rv), .HS_RDATA(hs_q),
		.HS_RVALID(hs_rv), .LOOP_DIFF(ld), .LOOP_VALID(lv), .LOOP_FROM_HOST(lh));
	dcrt_far far (.clk(clk), .rdata(fb_q), .acc(fb_acc), .bcast(bc), .cfg(cf), .pre(pre),
		.sof(sof), .eof(eof));
	task automatic end_sim();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic hs(input logic w, input logic [15:0] a, input logic [7:0] d, input logic e,
		output logic [7:0] q);
		hs_acc = '{wr: w, rd: !w, addr: a, wdata: d};
		hs_end = e;
		@(posedge clk) #1;
		q = hs_q;
	endtask
	task automatic rel();
		hs_acc = '{wr: 1'b0, rd: 1'b0, addr: ~hs_acc.addr, wdata: ~hs_acc.wdata};
		hs_end = 1'b0;
		far.rel();
	endtask
	task automatic rd(input logic h, input logic [15:0] a, input int n, output logic [63:0] v);
		logic [7:0] q;
		v = '0;
		for (int i = 0; i < n; i++) begin
			if (h) hs(1'b0, a + 16'(i), 8'h00, 1'b0, q);
			else far.op(1'b0, a + 16'(i), 8'h00, 2'b00, q);
			v[8*i +: 8] = q;
		end
		rel();
	endtask
	// Host writes always close the access on the fourth byte.
	task automatic wr(input logic h, input logic [15:0] a, input logic [31:0] v, input logic [1:0] c);
		logic [7:0] q;
		for (int i = 0; i < 4; i++) begin
			if (h) hs(1'b1, a + 16'(i), v[8*i +: 8], i == 3, q);
			else far.op(1'b1, a + 16'(i), v[8*i +: 8], c, q);
		end
		rel();
	endtask
	task automatic loopw(input logic exp, output logic [32:0] got);
		got = '0;
		repeat (4) begin
			if (lv === 1'b1) got = {lh, ld};
			rel();
		end
		if (exp && got === '0) begin
			chk(64'h0, 64'h1);
			end_sim();
		end
	endtask
	task automatic t_stamp(input logic [1:0] c, input logic p);
		logic [63:0] t0, a, b, u;
		po = p;
		t0 = lt;
		far.pulse(3'b001, 1'b1, 1'b0);
		far.pulse(3'b000, 1'b0, 1'b0);
		far.pulse(3'b010, 1'b0, 1'b0);
		repeat (2) far.pulse(3'b000, 1'b0, 1'b0);
		far.pulse(3'b100, 1'b0, 1'b0);
		rd(1'b0, RT0, 4, b);
		wr(1'b0, RT0, 32'h0, c);
		rd(1'b0, RT0, 4, u);
		chk(u, b);
		far.pulse(3'b000, 1'b0, 1'b1);
		rd(1'b0, RT0, 4, a);
		chk(a, {32'h0, t0[31:0]});
		rd(1'b0, RX_TIME_PORT_ONE_ADDR, 8, b);
		chk(b, {32'h0, t0[31:0] + 32'h2});
		rd(1'b0, RX_TIME_PROCESSING_UNIT_ADDR, 8, u);
		chk(u, t0 + (p ? 64'h0 : 64'h5));
		wr(1'b1, RT0, 32'hFFFF_FFFF, 2'b00);
		far.pulse(3'b111, 1'b1, 1'b0);
		wr(1'b0, RT0, 32'h0, 2'b00);
		far.pulse(3'b000, 1'b0, 1'b1);
		rd(1'b1, RT0, 4, u);
		chk(u, a);
		$display("stamp test done");
	endtask
	task automatic t_sys();
		logic [63:0] h, f;
		logic [32:0] got;
		logic [7:0] q;
		fork
			far.pulse(3'b000, 1'b1, 1'b0);
			hs(1'b0, ST, 8'h00, 1'b0, q);
		join
		repeat (300) rel();
		rd(1'b1, ST + 16'h1, 7, h);
		h = {h[55:0], q};
		rd(1'b0, ST, 4, f);
		chk(f, {32'h0, h[31:0] + 32'h1234});
		chk({32'h0, h[63:32]}, 64'h1);
		wr(1'b0, ST, f[31:0] + 32'h10, 2'b01);
		far.pulse(3'b000, 1'b0, 1'b1);
		loopw(1'b1, got);
		chk(64'(got), 64'h10);
		$display("system time test done");
	endtask
	task automatic t_host();
		logic [32:0] got;
		wr(1'b1, ST, 32'h1050, 2'b00);
		loopw(1'b0, got);
		chk(64'(got), 64'h0);
		ctrl = 1'b1;
		wr(1'b1, ST, 32'h1050, 2'b00);
		loopw(1'b1, got);
		chk(64'(got), 64'h1_0000_0050);
		far.pulse(3'b000, 1'b1, 1'b0);
		wr(1'b0, ST, 32'h0, 2'b01);
		far.pulse(3'b000, 1'b0, 1'b1);
		loopw(1'b0, got);
		chk(64'(got), 64'h0);
		ctrl = 1'b0;
		$display("host compare test done");
	endtask
	// A stalled clock enable must hold the local time, so later stamps track the frozen model.
	task automatic t_freeze();
		ce = 1'b0;
		repeat (5) rel();
		ce = 1'b1;
		t_stamp(2'b01, 1'b0);
		$display("clock enable test done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		t_stamp(2'b01, 1'b0);
		t_stamp(2'b10, 1'b1);
		t_sys();
		t_host();
		t_freeze();
		end_sim();
	end
endmodule
